// [bsbs_pkg.sv]
// Shared constants and types for the strap sense and boot sequencer
package bsbs_pkg;
   localparam int unsigned CLK_HZ = 10000000;
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned SENSE_WAIT_MS = 3;
   localparam int unsigned SENSE_WAIT_CYC = SENSE_WAIT_MS * (CLK_HZ / 1000);
   localparam int unsigned BOOT_LIMIT_S = 1;
   localparam int unsigned BOOT_LIMIT_CYC = BOOT_LIMIT_S * CLK_HZ - 1;
   localparam int unsigned DIG_RST_MIN_NS = 100;
   localparam int unsigned DIG_RST_MAX_NS = 1000;
   localparam int unsigned ANA_RST_MIN_NS = 10000;
   localparam int unsigned ANA_RST_CYC = (ANA_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SPI_DETECT_EDGES = 2;
   localparam int unsigned STRAP_W = 3;
   localparam int unsigned CLK_SEL_LO = 0;
   localparam int unsigned CLK_SEL_HI = 1;
   localparam int unsigned BOOT_SEL_BIT = 2;
   localparam logic [STRAP_W-1:0] STRAP_RESET = 3'h0;
   typedef enum logic [1:0] {BSBS_CLK_XTAL, BSBS_CLK_FS8K, BSBS_CLK_FS16K,
      BSBS_CLK_RSVD} bsbs_clk_t;
   typedef enum logic [1:0] {BSBS_PORT_NONE, BSBS_PORT_I2C, BSBS_PORT_SPI} bsbs_port_t;
endpackage

// [bsbs_rst_len.sv]
// Measures reset low time on the clock to tell a digital from an analog reset
`timescale 1ns/1ps
`default_nettype none
module bsbs_rst_len
   import bsbs_pkg::*;
#(
   parameter int unsigned ANA_CYC = ANA_RST_CYC
) (
   input wire logic clk,
   input wire logic rst_in_n,
   input wire logic por_n,
   output logic analog_rst
);
   // The valid clocks run during reset, so the low time is counted on the clock
   logic [15:0] low_cnt_r;
   logic analog_r;
   wire long_low = (low_cnt_r >= 16'(ANA_CYC));
   always_ff @(posedge clk or negedge por_n) begin
      if (!por_n) begin
         low_cnt_r <= 16'h0000;
         analog_r <= 1'b1;
      end else if (!rst_in_n) begin
         if (!long_low) begin
            low_cnt_r <= low_cnt_r + 16'h0001;
         end
         if (long_low) begin
            analog_r <= 1'b1;
         end
      end else begin
         low_cnt_r <= 16'h0000;
         analog_r <= 1'b0;
      end
   end
   assign analog_rst = analog_r | long_low;
endmodule
`default_nettype wire

// [bsbs_spi_detect.sv]
// Host port mode detector: two serial clock cycles select SPI, else I2C
`timescale 1ns/1ps
`default_nettype none
module bsbs_spi_detect
   import bsbs_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic host_sclk,
   input wire logic i2c_start,
   output bsbs_port_t port_mode
);
   logic sclk_d_r;
   logic [1:0] rise_cnt_r;
   bsbs_port_t mode_r;
   wire rise = host_sclk & ~sclk_d_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_d_r <= 1'b0;
         rise_cnt_r <= 2'h0;
         mode_r <= BSBS_PORT_NONE;
      end else begin
         sclk_d_r <= host_sclk;
         if (enable && mode_r == BSBS_PORT_NONE) begin
            // First interface to start the load locks the port
            if (rise && rise_cnt_r == 2'(SPI_DETECT_EDGES - 1)) begin
               mode_r <= BSBS_PORT_SPI;
            end else if (i2c_start) begin
               mode_r <= BSBS_PORT_I2C;
            end
            if (rise) begin
               rise_cnt_r <= rise_cnt_r + 2'h1;
            end
         end
      end
   end
   assign port_mode = mode_r;
endmodule
`default_nettype wire

// [bsbs_top.sv]
// Strap sense and boot sequencer top level
`timescale 1ns/1ps
`default_nettype none
module bsbs_top
   import bsbs_pkg::*;
#(
   parameter int unsigned WAIT_CYC = SENSE_WAIT_CYC,
   parameter int unsigned BOOT_CYC = BOOT_LIMIT_CYC,
   parameter int unsigned ANA_CYC = ANA_RST_CYC
) (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic POR_N,
   input wire logic [STRAP_W-1:0] STRAP_IN,
   input wire logic SUPPLY_SELECT_STRAP,
   input wire logic CORE_SUPPLY_GOOD,
   input wire logic PLL_LOCKED,
   input wire logic PORT_A_FRAME_SYNC,
   input wire logic PORT_A_BIT_CLOCK,
   input wire logic HOST_SCLK,
   input wire logic HOST_I2C_START,
   input wire logic HOST_LOAD_DONE,
   input wire logic FLASH_FW_DONE,
   input wire logic FLASH_CFG_DONE,
   input wire logic EVENT_ACK,
   output logic [STRAP_W-1:0] BOOT_SENSE,
   output logic SENSE_VALID,
   output bsbs_clk_t CLK_SOURCE,
   output logic CLK_SOURCE_BAD,
   output logic PLL_REF_FS,
   output logic REG_ENABLE,
   output logic PLL_ENABLE,
   output logic EVENT_POST,
   output logic EVENT_PENDING,
   output logic HOST_INTERRUPT_N,
   output logic HOST_INTERRUPT_N_OE,
   output logic FLASH_READ_EN,
   output logic FLASH_CHIP_SELECT_N,
   output logic FLASH_CHIP_SELECT_N_OE,
   output logic LOAD_CFG_PHASE,
   output bsbs_port_t HOST_PORT_MODE,
   output logic BOOT_DONE,
   output logic BOOT_TIMEOUT,
   output logic GPIO_STRAP_FREE,
   output logic ANALOG_RESET
);
   typedef enum logic [2:0] {S_SENSE, S_WAIT, S_REG, S_PLL, S_READY, S_LOAD_FW,
      S_LOAD_CFG, S_RUN} bsbs_state_t;

   bsbs_state_t state_r, state_nxt;
   logic [STRAP_W-1:0] strap_r;
   logic [31:0] wait_cnt_r;
   logic [31:0] boot_cnt_r;
   logic event_pend_r, event_done_r, event_post_r;
   logic int_n_r;
   logic reg_en_r, pll_en_r;
   logic timeout_r;
   logic analog_rst;
   bsbs_port_t port_mode;

   // Clock and boot source decode
   function automatic bsbs_clk_t bsbs_clk_decode(input logic [STRAP_W-1:0] s);
      unique case ({s[CLK_SEL_HI], s[CLK_SEL_LO]})
         2'h0: bsbs_clk_decode = BSBS_CLK_XTAL;
         2'h1: bsbs_clk_decode = BSBS_CLK_FS8K;
         2'h2: bsbs_clk_decode = BSBS_CLK_FS16K;
         2'h3: bsbs_clk_decode = BSBS_CLK_RSVD;
      endcase
   endfunction

   wire auto_boot = strap_r[BOOT_SEL_BIT];
   wire bsbs_clk_t clk_src = bsbs_clk_decode(strap_r);
   wire wait_done = (wait_cnt_r >= WAIT_CYC - 1);
   wire booting = (state_r != S_SENSE) && (state_r != S_WAIT) && (state_r != S_RUN);
   // The supply input is gated off when SUPPLY_SELECT_STRAP is set, so S_REG waits on CORE_SUPPLY_GOOD only with the strap low
   wire supply_ok = SUPPLY_SELECT_STRAP ? 1'b1 : CORE_SUPPLY_GOOD;
   wire host_en = (state_r == S_READY) && !auto_boot;

   // Regulator and PLL are held off only by an analog reset
   bsbs_rst_len #(
      .ANA_CYC(ANA_CYC)
   ) u_rst_len (
      .clk(REF_CLK),
      .rst_in_n(RST_N),
      .por_n(POR_N),
      .analog_rst(analog_rst)
   );

   bsbs_spi_detect u_spi_detect (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .enable(host_en),
      .host_sclk(HOST_SCLK),
      .i2c_start(HOST_I2C_START),
      .port_mode(port_mode)
   );

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         S_SENSE: state_nxt = S_WAIT;
         S_WAIT: if (wait_done) begin
            state_nxt = S_REG;
         end
         S_REG: if (supply_ok) begin
            state_nxt = S_PLL;
         end
         S_PLL: if (PLL_LOCKED) begin
            state_nxt = S_READY;
         end
         S_READY: if (auto_boot) begin
            state_nxt = S_LOAD_FW;
         end else if (port_mode != BSBS_PORT_NONE) begin
            state_nxt = S_LOAD_FW;
         end
         S_LOAD_FW: if (auto_boot ? FLASH_FW_DONE : HOST_LOAD_DONE) begin
            state_nxt = auto_boot ? S_LOAD_CFG : S_RUN;
         end
         S_LOAD_CFG: if (FLASH_CFG_DONE) begin
            state_nxt = S_RUN;
         end
         S_RUN: state_nxt = S_RUN;
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_r <= S_SENSE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Straps sampled once, then the pins belong to other functions
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         strap_r <= STRAP_RESET;
      end else if (state_r == S_SENSE) begin
         strap_r <= STRAP_IN;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         wait_cnt_r <= 32'h0;
      end else if (state_r == S_WAIT && !wait_done) begin
         wait_cnt_r <= wait_cnt_r + 32'h1;
      end
   end

   // Analog reset drops both supply control and PLL
   always_ff @(posedge REF_CLK or negedge POR_N) begin
      if (!POR_N) begin
         reg_en_r <= 1'b0;
         pll_en_r <= 1'b0;
      end else if (analog_rst) begin
         reg_en_r <= 1'b0;
         pll_en_r <= 1'b0;
      end else begin
         if (state_r == S_REG) begin
            reg_en_r <= !SUPPLY_SELECT_STRAP;
         end
         if (state_r == S_PLL) begin
            pll_en_r <= 1'b1;
         end
      end
   end

   // Ready event and interrupt, posted once per boot
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         event_pend_r <= 1'b0;
         event_done_r <= 1'b0;
         event_post_r <= 1'b0;
         int_n_r <= 1'b1;
      end else begin
         event_post_r <= 1'b0;
         if (state_r == S_READY && !event_done_r) begin
            event_done_r <= 1'b1;
            event_post_r <= 1'b1;
            event_pend_r <= 1'b1;
            int_n_r <= 1'b0;
         end else if (EVENT_ACK) begin
            // Set above wins over an acknowledge in the same cycle
            event_pend_r <= 1'b0;
            int_n_r <= 1'b1;
         end
      end
   end

   // Boot time supervision for flash boot
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         boot_cnt_r <= 32'h0;
         timeout_r <= 1'b0;
      end else if (auto_boot && booting) begin
         if (boot_cnt_r >= BOOT_CYC) begin
            timeout_r <= 1'b1;
         end else begin
            boot_cnt_r <= boot_cnt_r + 32'h1;
         end
      end
   end

   wire flash_active = auto_boot && (state_r == S_LOAD_FW || state_r == S_LOAD_CFG);

   assign BOOT_SENSE = strap_r;
   assign SENSE_VALID = (state_r != S_SENSE);
   assign CLK_SOURCE = clk_src;
   assign CLK_SOURCE_BAD = SENSE_VALID && (clk_src == BSBS_CLK_RSVD);
   assign PLL_REF_FS = (clk_src != BSBS_CLK_XTAL);
   assign REG_ENABLE = reg_en_r;
   assign PLL_ENABLE = pll_en_r;
   assign EVENT_POST = event_post_r;
   assign EVENT_PENDING = event_pend_r;
   // Open-drain style: only drives while asserting, released in reset
   assign HOST_INTERRUPT_N = int_n_r;
   assign HOST_INTERRUPT_N_OE = !int_n_r && RST_N;
   assign FLASH_READ_EN = flash_active;
   assign FLASH_CHIP_SELECT_N = !flash_active;
   assign FLASH_CHIP_SELECT_N_OE = auto_boot && SENSE_VALID && RST_N;
   assign LOAD_CFG_PHASE = (state_r == S_LOAD_CFG);
   assign HOST_PORT_MODE = port_mode;
   assign BOOT_DONE = (state_r == S_RUN);
   assign BOOT_TIMEOUT = timeout_r;
   assign GPIO_STRAP_FREE = SENSE_VALID;
   assign ANALOG_RESET = analog_rst;
endmodule
`default_nettype wire

// [bsbs_chk.sv]
// Port assertions for the strap sense and boot sequencer
`timescale 1ns/1ps
`default_nettype none
module bsbs_chk
   import bsbs_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic POR_N,
   input wire logic [STRAP_W-1:0] BOOT_SENSE,
   input wire logic SENSE_VALID,
   input wire bsbs_clk_t CLK_SOURCE,
   input wire logic CLK_SOURCE_BAD,
   input wire logic SUPPLY_SELECT_STRAP,
   input wire logic REG_ENABLE,
   input wire logic PLL_ENABLE,
   input wire logic EVENT_POST,
   input wire logic HOST_INTERRUPT_N,
   input wire logic HOST_INTERRUPT_N_OE,
   input wire logic FLASH_READ_EN,
   input wire logic FLASH_CHIP_SELECT_N,
   input wire logic FLASH_CHIP_SELECT_N_OE,
   input wire bsbs_port_t HOST_PORT_MODE,
   input wire logic ANALOG_RESET,
   input wire logic PLL_REF_FS,
   input wire logic EVENT_PENDING,
   input wire logic LOAD_CFG_PHASE,
   input wire logic GPIO_STRAP_FREE
);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_N);
   property p_hold; SENSE_VALID && $past(SENSE_VALID) |-> $stable(BOOT_SENSE); endproperty
   a_hold: assert property (p_hold) else $error("sense moved");
   property p_clk; SENSE_VALID |-> CLK_SOURCE == bsbs_clk_t'(BOOT_SENSE[1:0])
      && CLK_SOURCE_BAD == &BOOT_SENSE[1:0]; endproperty
   a_clk: assert property (p_clk) else $error("clock source");
   property p_pll; $rose(PLL_ENABLE) && !SUPPLY_SELECT_STRAP |-> REG_ENABLE; endproperty
   a_pll: assert property (p_pll) else $error("pll before supply");
   property p_int; $fell(HOST_INTERRUPT_N) |-> EVENT_POST && PLL_ENABLE; endproperty
   a_int: assert property (p_int) else $error("interrupt early");
   property p_once; EVENT_POST |=> !EVENT_POST [*8]; endproperty
   a_once: assert property (p_once) else $error("event repeated");
   property p_oe; disable iff (!POR_N)
      !RST_N |-> !HOST_INTERRUPT_N_OE && !FLASH_CHIP_SELECT_N_OE; endproperty
   a_oe: assert property (p_oe) else $error("driving in reset");
   property p_cs; SENSE_VALID |-> FLASH_CHIP_SELECT_N_OE == BOOT_SENSE[2]; endproperty
   a_cs: assert property (p_cs) else $error("chip select pin");
   property p_rd; $rose(FLASH_READ_EN) |-> BOOT_SENSE[2] ##[0:1] !FLASH_CHIP_SELECT_N; endproperty
   a_rd: assert property (p_rd) else $error("flash read");
   property p_port; HOST_PORT_MODE != BSBS_PORT_NONE |-> !BOOT_SENSE[2]; endproperty
   a_port: assert property (p_port) else $error("host port in auto boot");
   property p_ana; disable iff (!POR_N)
      ANALOG_RESET |=> !REG_ENABLE && !PLL_ENABLE; endproperty
   a_ana: assert property (p_ana) else $error("enables kept");
   property p_ref; SENSE_VALID |-> PLL_REF_FS == (BOOT_SENSE[1:0] != 2'h0); endproperty
   a_ref: assert property (p_ref) else $error("pll reference source");
   property p_pend; EVENT_POST |-> EVENT_PENDING && !HOST_INTERRUPT_N
      && HOST_INTERRUPT_N_OE; endproperty
   a_pend: assert property (p_pend) else $error("event not pending");
   property p_cfg; LOAD_CFG_PHASE |-> BOOT_SENSE[2] && FLASH_READ_EN; endproperty
   a_cfg: assert property (p_cfg) else $error("config phase outside flash");
   property p_free; GPIO_STRAP_FREE && $past(GPIO_STRAP_FREE) |-> $stable(BOOT_SENSE);
   endproperty
   a_free: assert property (p_free) else $error("freed strap moved sense");
endmodule
`default_nettype wire

// [bsbs_partner.sv]
// Far side model: core supply, PLL lock and serial flash segments
`timescale 1ns/1ps
`default_nettype none
module bsbs_partner (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic reg_en,
   input wire logic pll_en,
   input wire logic rd_en,
   output logic supply_good,
   output logic pll_locked,
   output logic fw_done,
   output logic cfg_done
);
   logic [7:0] sup_r;
   logic [7:0] pll_r;
   logic [7:0] rd_r;
   logic [7:0] lim;
   assign lim = slow ? 8'h50 : 8'h03;
   // Supply and PLL restart only when their enables drop, as after a long reset
   always_ff @(posedge clk) begin
      sup_r <= !reg_en ? 8'h00 : sup_r + {7'h0, sup_r != 8'hFF};
      pll_r <= !pll_en ? 8'h00 : pll_r + {7'h0, pll_r != 8'hFF};
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_r <= 8'h00;
      end else begin
         rd_r <= rd_r + {7'h0, rd_en && rd_r != 8'hFF};
      end
   end
   assign supply_good = sup_r >= lim;
   assign pll_locked = pll_r >= lim;
   assign fw_done = rd_r >= lim;
   assign cfg_done = rd_r >= {lim[6:0], 1'b0};
endmodule
`default_nettype wire

// [tb_bsbs_top.sv]
// Self-checking bench for the strap sense and boot sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_bsbs_top
   import bsbs_pkg::*;
   ;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic por_n = 1'b0;
   logic ext = 1'b0;
   logic sclk = 1'b0;
   logic i2c = 1'b0;
   logic hdone = 1'b0;
   logic ack = 1'b0;
   logic slow = 1'b0;
   logic [2:0] strap = 3'h0;
   logic sg, lk, fwd, cfd, post, done, tmo, sv, rd, pen, ren, sv_d, done_d, pend, intn;
   logic [2:0] sense;
   bsbs_clk_t csrc;
   bsbs_port_t pmode;
   int seed = 66605;
   int n_mismatch = 0;
   int n_checks = 0;
   logic [4:0] q_s[$];
   logic [4:0] q_b[$];
   always #50 clk = ~clk;
   bsbs_top #(.WAIT_CYC(10), .BOOT_CYC(200), .ANA_CYC(5)) dut (
      .REF_CLK(clk), .RST_N(rst_n), .POR_N(por_n), .STRAP_IN(strap),
      .SUPPLY_SELECT_STRAP(ext), .CORE_SUPPLY_GOOD(sg), .PLL_LOCKED(lk),
      .PORT_A_FRAME_SYNC(1'b0), .PORT_A_BIT_CLOCK(1'b0), .HOST_SCLK(sclk),
      .HOST_I2C_START(i2c), .HOST_LOAD_DONE(hdone), .FLASH_FW_DONE(fwd),
      .FLASH_CFG_DONE(cfd), .EVENT_ACK(ack), .BOOT_SENSE(sense), .SENSE_VALID(sv),
      .CLK_SOURCE(csrc), .CLK_SOURCE_BAD(), .PLL_REF_FS(), .REG_ENABLE(ren),
      .PLL_ENABLE(pen), .EVENT_POST(post), .EVENT_PENDING(pend), .HOST_INTERRUPT_N(intn),
      .HOST_INTERRUPT_N_OE(), .FLASH_READ_EN(rd), .FLASH_CHIP_SELECT_N(),
      .FLASH_CHIP_SELECT_N_OE(), .LOAD_CFG_PHASE(), .HOST_PORT_MODE(pmode),
      .BOOT_DONE(done), .BOOT_TIMEOUT(tmo), .GPIO_STRAP_FREE(), .ANALOG_RESET());
   bsbs_partner far (.clk(clk), .rst_n(rst_n), .slow(slow), .reg_en(ren), .pll_en(pen),
      .rd_en(rd), .supply_good(sg), .pll_locked(lk), .fw_done(fwd), .cfg_done(cfd));
   task automatic bad(input string msg);
      n_mismatch++;
      $display("BAD %0t %s", $time, msg);
   endtask
   task automatic cmp_sense(input logic [4:0] got, input logic [4:0] exp);
      n_checks++;
      if (got !== exp) bad("sensed straps or clock source");
   endtask
   task automatic cmp_done(input logic [4:0] got, input logic [4:0] exp);
      n_checks++;
      if (got !== exp) bad("port mode, timeout or interrupt state at done");
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      if (rst_n && sv && !sv_d) cmp_sense({csrc, sense}, q_s.pop_front());
      if (rst_n && done && !done_d) cmp_done({pmode, tmo, pend, intn}, q_b.pop_front());
      sv_d = sv;
      done_d = done;
   end
   // Host traffic is sent in auto boot too, where it must be ignored
   task automatic boot(input logic [2:0] s, input logic lng, input logic spi);
      int i;
      @(posedge clk);
      #1 rst_n = 1'b0;
      strap = s;
      ext = 1'($random(seed));
      slow = lng & s[2];
      q_s.push_back({s[1:0], s});
      // Event acknowledged long before done: nothing pending, interrupt released
      q_b.push_back({s[2] ? BSBS_PORT_NONE : (spi ? BSBS_PORT_SPI : BSBS_PORT_I2C), slow,
         1'b0, 1'b1});
      repeat (lng ? 8 : 3) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge clk);
      #1 strap = 3'($random(seed));
      for (i = 0; i < 400 && !post; i++) @(posedge clk);
      #1 ack = 1'b1;
      if (i == 400) bad("no ready event");
      @(posedge clk);
      #1 ack = 1'b0;
      for (i = 0; i < 4; i++) begin
         if (spi) sclk = ~sclk;
         else i2c = (i == 0);
         repeat (2) @(posedge clk);
         #1;
      end
      hdone = 1'b1;
      for (i = 0; i < 400 && !done; i++) @(posedge clk);
      #1 hdone = 1'b0;
      if (i == 400) bad("boot never done");
   endtask
   initial begin
      int k;
      repeat (12) @(posedge clk);
      #1 por_n = 1'b1;
      for (k = 0; k < 12; k++) boot(k < 8 ? k[2:0] : 3'($random(seed)), k[0], k[1]);
      end_sim;
   end
   initial begin
      #3000000;
      n_mismatch++;
      end_sim;
   end
endmodule
bind bsbs_top bsbs_chk u_chk (.*);
`default_nettype wire
